// [hdl/pwsw_pkg.sv]
package pwsw_pkg;
	// clock rate
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	// printed times in nanoseconds
	localparam int MIN_IDLE_HIGH_TIME_NS   = 11_000;
	localparam int EDGE_DETECT_WINDOW_NS   = 9_600;
	localparam int MASTER_ZERO_MIN_NS      = 11_800;
	localparam int MASTER_ZERO_MAX_NS      = 17_000;
	localparam int MASTER_ONE_MIN_NS       = 35_400;
	localparam int MASTER_ONE_MAX_NS       = 48_900;
	localparam int SLAVE_READ_ONE_MIN_NS   = 28_300;
	localparam int SLAVE_READ_ONE_MAX_NS   = 38_300;
	localparam int START_MIN_NS            = 80_000;
	localparam int START_MAX_NS            = 109_000;
	localparam int SLAVE_ATTENTION_MIN_NS  = 165_000;
	localparam int SLAVE_ATTENTION_MAX_NS  = 228_000;
	localparam int RESET_MIN_NS            = 354_000;
	// cycle counts: least times round up
	localparam int IDLE_CYC    = (MIN_IDLE_HIGH_TIME_NS + CLK_NS - 1) / CLK_NS;
	// edge window is a longest time: round down
	localparam int EDGE_CYC    = EDGE_DETECT_WINDOW_NS / CLK_NS;
	// own drive targets at the middle of each band, reset at its least time plus 50000 ns rounded up
	localparam int RD1_CYC     = (SLAVE_READ_ONE_MIN_NS + SLAVE_READ_ONE_MAX_NS) / 2 / CLK_NS;
	localparam int ATTN_CYC    = (SLAVE_ATTENTION_MIN_NS + SLAVE_ATTENTION_MAX_NS) / 2 / CLK_NS;
	localparam int RST_CYC     = (RESET_MIN_NS + 50_000 + CLK_NS - 1) / CLK_NS;
	// classification thresholds between neighbouring bands
	localparam int TH01_CYC    = (MASTER_ZERO_MAX_NS + SLAVE_READ_ONE_MIN_NS) / 2 / CLK_NS;
	localparam int TH1S_CYC    = (MASTER_ONE_MAX_NS + START_MIN_NS) / 2 / CLK_NS;
	localparam int THSA_CYC    = (START_MAX_NS + SLAVE_ATTENTION_MIN_NS) / 2 / CLK_NS;
	localparam int THAR_CYC    = (SLAVE_ATTENTION_MAX_NS + RESET_MIN_NS) / 2 / CLK_NS;
	// bits the master must send before an attention is allowed
	localparam int ATTN_GATE_BITS = 14;
	localparam int CNT_W = 14;
	// symbol codes
	typedef enum logic [2:0] {
		PWSW_SYM_ZERO  = 3'h0,
		PWSW_SYM_ONE   = 3'h1,
		PWSW_SYM_START = 3'h2,
		PWSW_SYM_ATTN  = 3'h3,
		PWSW_SYM_RESET = 3'h4
	} pwsw_sym_t;
endpackage

// [hdl/pwsw_line_meter.sv]
`timescale 1ns/1ps
// measures the low time and high time of the synchronised line
module pwsw_line_meter
	import pwsw_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// line
	input  wire logic             line_in,
	// measurements
	output logic                  line_low,
	output logic                  fall_pulse,
	output logic                  rise_pulse,
	output logic [CNT_W-1:0]      low_count,
	output logic                  bus_idle
);
	logic                  sync_a;
	logic                  sync_b;
	logic [CNT_W-1:0]      high_count;

	// two-flop synchroniser; first stage read only by the second
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= line_in;
			sync_b <= sync_a;
		end
	end

	// edge pulses and delayed level
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			line_low   <= 1'b0;
			fall_pulse <= 1'b0;
			rise_pulse <= 1'b0;
		end else begin
			line_low   <= !sync_b;
			fall_pulse <= !sync_b && !line_low;
			rise_pulse <= sync_b && line_low;
		end
	end

	// low duration counter, saturating, holds its value after the rise
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			low_count <= '0;
		end else if (!sync_b && !line_low) begin
			low_count <= CNT_W'(1);
		end else if (!sync_b && low_count != '1) begin
			low_count <= low_count + CNT_W'(1); // [R24]
		end
	end

	// high duration: idle once high for the least idle time
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			high_count <= '0;
			bus_idle   <= 1'b0;
		end else if (!sync_b) begin
			high_count <= '0;
			bus_idle   <= 1'b0;
		end else begin
			if (high_count != '1)
				high_count <= high_count + CNT_W'(1);
			bus_idle <= (high_count >= CNT_W'(IDLE_CYC)); // [R2]
		end
	end
endmodule

// [hdl/pwsw_bit_layer.sv]
`timescale 1ns/1ps
// Behaviour
// [R1] five symbols, told apart by low time only
// [R2] bus idle after least high time
// [R3] drive low only, open drain
// [R4] master starts every data bit
// [R5] time written bit low period
// [R6] read one: sensor stretches low pulse
// [R7] longer symbol is not a data bit
// [R8] unused register bits read as zero
// [R9] master waits idle before start
// [R10] start aborts current transaction always
// [R11] attention or reset voids a start; the code clears in_xfer on a reset only
// [R12] attention only from idle bus
// [R13] attention overrides data and start
// [R14] check idle or join edge, hold attention
// [R15] long attention becomes reset
// [R16] attention gated until 14 master bits
// [R17] sensor issues reset at power up
// [R18] own timing within fifteen percent
// [R19] address from two strap pins
// [R20] master zero and one pulse bands
// [R21] detect in window, read one length
// [R22] start and attention pulse bands
// [R23] reset length, idle before attention
// [R24] synchronise, count, classify by thresholds
module pwsw_bit_layer
	import pwsw_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// single-wire line, open drain
	input  wire logic        swd_in,
	output logic             swd_out,
	output logic             swd_oe,
	// address straps
	input  wire logic [1:0]  addr_strap,
	output logic [1:0]       dev_addr,
	// transmit side: value of the next read slot
	input  wire logic        tx_bit,
	input  wire logic        tx_bit_used,
	// attention request from the sensor core
	input  wire logic        attn_req,
	output logic             attn_done,
	output logic             attn_lost,
	// received symbols
	output logic             sym_valid,
	output pwsw_pkg::pwsw_sym_t sym_code,
	output logic             rx_bit,
	output logic             xfer_abort,
	output logic             bus_reset_seen,
	output logic             attn_allowed
);
	import pwsw_pkg::*;

	typedef enum logic [4:0] {
		PWSW_ST_PWRUP = 5'h01,
		PWSW_ST_WAIT  = 5'h02,
		PWSW_ST_RD1   = 5'h04,
		PWSW_ST_ATTN  = 5'h08,
		PWSW_ST_HOLD  = 5'h10
	} pwsw_st_t;

	logic              line_low;
	logic              fall_pulse;
	logic              rise_pulse;
	logic [CNT_W-1:0]  low_count;
	logic              bus_idle;
	pwsw_st_t          state;
	logic [CNT_W-1:0]  drive_count;
	logic [4:0]        bit_count;
	logic              strap_taken;
	logic              in_xfer;
	logic              attn_pending;
	logic              attn_own;
	pwsw_sym_t         next_sym;

	pwsw_line_meter u_meter (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.line_in    (swd_in),
		.line_low   (line_low),
		.fall_pulse (fall_pulse),
		.rise_pulse (rise_pulse),
		.low_count  (low_count),
		.bus_idle   (bus_idle)
	);

	// pulse class from the finished low time
	always_comb begin
		if (low_count >= CNT_W'(THAR_CYC))
			next_sym = PWSW_SYM_RESET; // [R15]
		else if (low_count >= CNT_W'(THSA_CYC))
			next_sym = PWSW_SYM_ATTN; // [R13]
		else if (low_count >= CNT_W'(TH1S_CYC))
			next_sym = PWSW_SYM_START; // [R11]
		else if (low_count >= CNT_W'(TH01_CYC))
			next_sym = PWSW_SYM_ONE; // [R5]
		else
			next_sym = PWSW_SYM_ZERO; // [R1]
	end

	// straps caught once after reset release, clocked so no async load
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			strap_taken <= 1'b0;
			dev_addr    <= 2'h0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			dev_addr    <= addr_strap; // [R19]
		end
	end

	// symbol report at every rising edge of the line except in power-up
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sym_valid <= 1'b0;
			sym_code  <= PWSW_SYM_ZERO;
			rx_bit    <= 1'b0;
		end else begin
			sym_valid <= rise_pulse && state != PWSW_ST_PWRUP;
			if (rise_pulse) begin
				sym_code <= next_sym; // [R7]
				rx_bit   <= (next_sym == PWSW_SYM_ONE); // [R6]
			end
		end
	end

	// transaction tracking; start marks the beginning, a later one aborts
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			in_xfer        <= 1'b0;
			xfer_abort     <= 1'b0;
			bus_reset_seen <= 1'b0;
		end else begin
			xfer_abort     <= 1'b0;
			bus_reset_seen <= 1'b0;
			if (rise_pulse) begin
				case (next_sym)
					PWSW_SYM_START: begin
						xfer_abort <= in_xfer; // [R10]
						in_xfer    <= 1'b1; // [R9]
					end
					PWSW_SYM_RESET: begin
						in_xfer        <= 1'b0;
						bus_reset_seen <= 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// master bit counter since last reset gates attention
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bit_count    <= 5'h00;
			attn_allowed <= 1'b0;
		end else if (rise_pulse && next_sym == PWSW_SYM_RESET) begin
			bit_count    <= 5'h00;
			attn_allowed <= 1'b0;
		end else begin
			if (rise_pulse && !attn_own && bit_count < 5'(ATTN_GATE_BITS)
				&& (next_sym == PWSW_SYM_ZERO || next_sym == PWSW_SYM_ONE))
				bit_count <= bit_count + 5'h01; // [R4]
			attn_allowed <= (bit_count >= 5'(ATTN_GATE_BITS)); // [R16]
		end
	end

	// pending attention: a new request wins over the clear at completion
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			attn_pending <= 1'b0;
		end else if (attn_req) begin
			attn_pending <= 1'b1;
		end else if (state == PWSW_ST_ATTN && drive_count == CNT_W'(1)) begin
			attn_pending <= 1'b0;
		end
	end

	// line driver: power-up reset, read one, attention
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state       <= PWSW_ST_PWRUP;
			drive_count <= CNT_W'(RST_CYC); // [R17]
			swd_out     <= 1'b0;
			swd_oe      <= 1'b1;
			attn_own    <= 1'b0;
			attn_done   <= 1'b0;
			attn_lost   <= 1'b0;
		end else begin
			swd_out   <= 1'b0; // [R3]
			attn_done <= 1'b0;
			attn_lost <= 1'b0;
			case (state)
				PWSW_ST_PWRUP: begin
					if (drive_count == CNT_W'(1)) begin
						swd_oe <= 1'b0;
						state  <= PWSW_ST_HOLD;
					end else begin
						drive_count <= drive_count - CNT_W'(1);
					end
				end
				PWSW_ST_WAIT: begin
					if (attn_pending && attn_allowed && bus_idle) begin
						// idle check holds the least high time before attention
						swd_oe      <= 1'b1; // [R12] [R23]
						attn_own    <= 1'b1;
						drive_count <= CNT_W'(ATTN_CYC); // [R22]
						state       <= PWSW_ST_ATTN;
					end else if (fall_pulse && attn_pending && attn_allowed) begin
						// join a master edge inside the detect window
						swd_oe      <= 1'b1; // [R14]
						attn_own    <= 1'b1;
						drive_count <= CNT_W'(ATTN_CYC);
						state       <= PWSW_ST_ATTN;
					end else if (fall_pulse && in_xfer && tx_bit_used && tx_bit) begin
						// reserved bits arrive as zero and leave the line alone
						swd_oe      <= 1'b1; // [R8] [R21]
						drive_count <= CNT_W'(RD1_CYC);
						state       <= PWSW_ST_RD1;
					end
				end
				PWSW_ST_RD1: begin
					if (drive_count == CNT_W'(1)) begin
						swd_oe <= 1'b0; // [R18]
						state  <= PWSW_ST_HOLD;
					end else begin
						drive_count <= drive_count - CNT_W'(1);
					end
				end
				PWSW_ST_ATTN: begin
					if (drive_count == CNT_W'(1)) begin
						swd_oe    <= 1'b0;
						attn_done <= 1'b1;
						state     <= PWSW_ST_HOLD;
					end else begin
						drive_count <= drive_count - CNT_W'(1);
					end
				end
				PWSW_ST_HOLD: begin
					// wait for the line to rise before looking for more
					if (!line_low) begin
						if (attn_own && low_count >= CNT_W'(THAR_CYC))
							attn_lost <= 1'b1; // [R15]
						attn_own <= 1'b0;
						state    <= PWSW_ST_WAIT;
					end
				end
				default: begin
					swd_oe <= 1'b0;
					state  <= PWSW_ST_WAIT;
				end
			endcase
		end
	end
endmodule

// [verif/pwsw_bit_layer_chk.sv]
`timescale 1ns/1ps
// relations between line drive, symbols and the attention gate
module pwsw_bit_layer_chk
	import pwsw_pkg::*;
(
	// clock and reset
	input wire logic                ref_clk,
	input wire logic                rst_n,
	// line and straps
	input wire logic                swd_in,
	input wire logic                swd_out,
	input wire logic                swd_oe,
	input wire logic [1:0]          addr_strap,
	input wire logic [1:0]          dev_addr,
	// results
	input wire logic                attn_done,
	input wire logic                sym_valid,
	input wire pwsw_pkg::pwsw_sym_t sym_code,
	input wire logic                rx_bit,
	input wire logic                xfer_abort,
	input wire logic                bus_reset_seen,
	input wire logic                attn_allowed
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic pu;
	int   pu_cnt;
	int   oe_cnt;
	// power-up drive starts inside reset, so it is timed on its own
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pu <= 1'b1;
			pu_cnt <= 0;
		end else if (pu) begin
			pu_cnt <= pu_cnt + 1;
			pu <= swd_oe;
		end
	end
	// length of each own low drive
	always_ff @(posedge ref_clk) begin
		oe_cnt <= swd_oe ? oe_cnt + 1 : 0;
	end
	a_out_low: assert property (swd_out == 1'b0)
		else $error("line driven high");
	a_powerup_len: assert property (pu && !swd_oe |-> pu_cnt >= 8850)
		else $error("power-up drive too short");
	a_drive_band: assert property ($fell(swd_oe) |-> oe_cnt inside {[700:960], [4120:5710]}
		|| oe_cnt >= 8850)
		else $error("own drive length off band");
	a_attn_idle: assert property ($rose(swd_oe) && $past(swd_in) |-> attn_allowed)
		else $error("attention started while gated");
	a_done_gated: assert property (attn_done |-> attn_allowed)
		else $error("attention done while gated");
	a_reset_gate: assert property (bus_reset_seen |-> ##[0:2] !attn_allowed)
		else $error("gate not closed by reset");
	a_strap_latch: assert property ($rose(rst_n) |=> dev_addr == $past(addr_strap))
		else $error("strap not latched");
	a_sym_high: assert property (sym_valid |-> swd_in)
		else $error("symbol while line low");
	a_zero_bit: assert property (sym_valid && sym_code == PWSW_SYM_ZERO |-> !rx_bit)
		else $error("zero symbol with bit set");
	a_one_bit: assert property (sym_valid && sym_code == PWSW_SYM_ONE |-> rx_bit)
		else $error("one symbol with bit clear");
	a_abort_start: assert property (xfer_abort |-> sym_code == PWSW_SYM_START)
		else $error("abort without start");
endmodule

// [verif/pwsw_master_model.sv]
`timescale 1ns/1ps
// bus master: waits for an idle bus, then pulls low for one symbol
module pwsw_master_model
	import pwsw_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// line
	input wire logic line_in,
	output logic     drive_low
);
	int run = 0;
	int last_low = 0;
	initial drive_low = 1'b0;
	// last low period seen on the wire, whoever drove it
	always @(posedge ref_clk) begin
		run <= line_in ? 0 : run + 1;
		if (line_in && run != 0)
			last_low <= run;
	end
	// pulse lengths near the middle of the zero, one and start bands; attention and reset both get the reset length
	function automatic int len(input pwsw_sym_t s);
		case (s)
			PWSW_SYM_ZERO: return 350;
			PWSW_SYM_ONE: return 1050;
			PWSW_SYM_START: return 2250;
			default: return 10000;
		endcase
	endfunction
	task automatic send_sym(input pwsw_sym_t s);
		int idle;
		int n;
		idle = 0;
		n = 0;
		// inactive bus before any data or start
		while (idle < IDLE_CYC) begin
			@(posedge ref_clk);
			idle = line_in ? idle + 1 : 0;
		end
		// low only, the pull-up restores high
		drive_low <= 1'b1;
		repeat (len(s)) @(posedge ref_clk);
		drive_low <= 1'b0;
		// the sensor may still hold the line
		while (!line_in && n < 8000) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
endmodule

// [verif/test_pwsw_bit_layer.sv]
`timescale 1ns/1ps
// bit layer against a master model on a pulled-up line
module test_pwsw_bit_layer;
	import pwsw_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rst_n, tx_bit, tx_bit_used, attn_req, master_low, got_bit;
	logic       swd_out, swd_oe, attn_done, attn_lost, sym_valid, rx_bit;
	logic       xfer_abort, bus_reset_seen, attn_allowed, abort_seen, done_seen;
	logic [1:0] addr_strap, dev_addr;
	logic [2:0] got_code;
	pwsw_sym_t  sym_code;
	int         num_errors = 0;
	int         tests_run = 0;
	// open-drain wire, high unless someone pulls
	wire        swd = !(swd_oe || master_low);
	initial begin
		forever #20 ref_clk = !ref_clk;
	end
	pwsw_bit_layer i_pwsw_bit_layer (.ref_clk(ref_clk), .rst_n(rst_n), .swd_in(swd),
		.swd_out(swd_out), .swd_oe(swd_oe), .addr_strap(addr_strap), .dev_addr(dev_addr),
		.tx_bit(tx_bit), .tx_bit_used(tx_bit_used), .attn_req(attn_req), .attn_done(attn_done),
		.attn_lost(attn_lost), .sym_valid(sym_valid), .sym_code(sym_code), .rx_bit(rx_bit),
		.xfer_abort(xfer_abort), .bus_reset_seen(bus_reset_seen), .attn_allowed(attn_allowed));
	pwsw_master_model i_pwsw_master_model (.ref_clk(ref_clk), .line_in(swd),
		.drive_low(master_low));
	// keep what the block reports between checks
	always @(posedge ref_clk) begin
		if (sym_valid) begin
			got_code <= sym_code;
			got_bit <= rx_bit;
		end
		if (xfer_abort)
			abort_seen <= 1'b1;
		if (attn_done)
			done_seen <= 1'b1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic sym_chk(input pwsw_sym_t s, input pwsw_sym_t exp);
		got_code = 3'h7;
		i_pwsw_master_model.send_sym(s);
		repeat (8) @(negedge ref_clk);
		chk(got_code, exp);
		if (exp == PWSW_SYM_ZERO || exp == PWSW_SYM_ONE)
			chk(got_bit, exp == PWSW_SYM_ONE);
	endtask
	task automatic t_powerup;
		int n;
		n = 0;
		while (swd_oe !== 1'b0 && n < 12000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 8850 && n <= RST_CYC + 4, 1'b1);
		chk(dev_addr, addr_strap);
	endtask
	task automatic t_bus_reset;
		sym_chk(PWSW_SYM_RESET, PWSW_SYM_RESET);
		chk(attn_allowed, 1'b0);
	endtask
	task automatic t_attn_gate;
		int n;
		n = 0;
		@(posedge ref_clk);
		attn_req <= 1'b1;
		@(posedge ref_clk);
		attn_req <= 1'b0;
		repeat (500) @(negedge ref_clk);
		chk(swd_oe, 1'b0);
		sym_chk(PWSW_SYM_START, PWSW_SYM_START);
		for (int i = 0; i < 14; i++) begin
			chk(attn_allowed, 1'b0);
			sym_chk(i[0] ? PWSW_SYM_ONE : PWSW_SYM_ZERO, i[0] ? PWSW_SYM_ONE : PWSW_SYM_ZERO);
		end
		chk(attn_allowed, 1'b1);
		while (!done_seen && n < 8000) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (4) @(negedge ref_clk);
		chk(done_seen, 1'b1);
		chk(i_pwsw_master_model.last_low inside {[4120:5710]}, 1'b1);
	endtask
	task automatic t_read;
		@(posedge ref_clk);
		tx_bit_used <= 1'b1;
		tx_bit <= 1'b1;
		sym_chk(PWSW_SYM_START, PWSW_SYM_START);
		sym_chk(PWSW_SYM_ZERO, PWSW_SYM_ONE);
		chk(i_pwsw_master_model.last_low inside {[700:960]}, 1'b1);
		@(posedge ref_clk);
		tx_bit <= 1'b0;
		sym_chk(PWSW_SYM_ZERO, PWSW_SYM_ZERO);
		chk(i_pwsw_master_model.last_low < 400, 1'b1);
		@(posedge ref_clk);
		tx_bit_used <= 1'b0;
	endtask
	task automatic t_abort;
		// the read scenario left a transfer open, so this start may abort it
		sym_chk(PWSW_SYM_START, PWSW_SYM_START);
		abort_seen = 1'b0;
		sym_chk(PWSW_SYM_ONE, PWSW_SYM_ONE);
		chk(abort_seen, 1'b0);
		sym_chk(PWSW_SYM_START, PWSW_SYM_START);
		chk(abort_seen, 1'b1);
	endtask
	task automatic give_verdict;
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		tx_bit = 1'b0;
		tx_bit_used = 1'b0;
		attn_req = 1'b0;
		addr_strap = 2'h2;
		abort_seen = 1'b0;
		done_seen = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_powerup;
		t_bus_reset;
		t_attn_gate;
		t_read;
		t_abort;
		give_verdict;
	end
	// hang guard, about twice the expected run
	initial begin
		#4_000_000;
		num_errors++;
		give_verdict;
	end
endmodule
bind pwsw_bit_layer pwsw_bit_layer_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.swd_in(swd_in), .swd_out(swd_out), .swd_oe(swd_oe), .addr_strap(addr_strap),
	.dev_addr(dev_addr), .attn_done(attn_done), .sym_valid(sym_valid), .sym_code(sym_code),
	.rx_bit(rx_bit), .xfer_abort(xfer_abort), .bus_reset_seen(bus_reset_seen),
	.attn_allowed(attn_allowed));
